// [rtl/tick_pkg.sv]
// Purpose: shared constants for the timer tick prescaler and clock select
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes:   tick source codes are fixed by the timer clock-select field
package tick_pkg;
	localparam int         ADDR_W         = 8;
	localparam int         NUM_TIMERS     = 3;
	localparam int         SEL_W          = 3;
	localparam int         SEL_STRIDE     = 4;
	localparam int         PRESC_W        = 10;
	localparam int         CNT_W          = 16;
	localparam logic [7:0] CTRL_OFF       = 8'h00;
	localparam logic [7:0] SEL_OFF        = 8'h04;
	localparam logic [7:0] PRESC_OFF      = 8'h08;
	localparam logic [7:0] CNT_OFF        = 8'h10;
	localparam logic [7:0] CNT_STRIDE     = 8'h04;
	localparam int         HOLD_BIT       = 7;
	localparam int         SHARED_PSR_BIT = 0;
	localparam int         OTHER_PSR_BIT  = 1;
	localparam logic [7:0] CTRL_MASK      = 8'h83;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [11:0] SEL_MASK      = 12'h777;
	localparam logic [11:0] SEL_RESET     = 12'h000;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam int         DIV8_LOG2      = 3;
	localparam int         DIV64_LOG2     = 6;
	localparam int         DIV256_LOG2    = 8;
	localparam int         DIV1024_LOG2   = 10;
	localparam logic [1:0] RESP_OKAY      = 2'b00;
	localparam logic [1:0] RESP_SLVERR    = 2'b10;

	typedef enum logic [2:0] {
		SEL_STOP     = 3'b000,
		SEL_DIRECT   = 3'b001,
		SEL_DIV8     = 3'b010,
		SEL_DIV64    = 3'b011,
		SEL_DIV256   = 3'b100,
		SEL_DIV1024  = 3'b101,
		SEL_EXT_FALL = 3'b110,
		SEL_EXT_RISE = 3'b111
	} tick_src_t;
endpackage : tick_pkg

// [rtl/ext_pin_if.sv]
// Purpose: carries count pins and detected edges between top and synchroniser
// Assumes: one pin per timer
// Notes:   ce freezes the synchroniser together with the rest of the block
`timescale 1ns/1ns
interface ext_pin_if;
	logic [tick_pkg::NUM_TIMERS-1:0] pin;
	logic                            ce;
	logic [tick_pkg::NUM_TIMERS-1:0] rise;
	logic [tick_pkg::NUM_TIMERS-1:0] fall;
	modport sync (input pin, input ce, output rise, output fall);
	modport user (output pin, output ce, input rise, input fall);
endinterface : ext_pin_if

// [rtl/ext_pin_sync.sv]
// Purpose: samples the external count pins and detects their edges
// Assumes: pins synchronous to aclk; half periods longer than one cycle
// Notes:   edge pulse is high three edges after the pin change
`timescale 1ns/1ns
module ext_pin_sync (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins in, edges out
	ext_pin_if.sync  port
);
	import tick_pkg::*;

	logic [NUM_TIMERS-1:0] stage1;
	logic [NUM_TIMERS-1:0] stage2;
	logic [NUM_TIMERS-1:0] prev;
	logic [NUM_TIMERS-1:0] next_stage1;
	logic [NUM_TIMERS-1:0] next_stage2;
	logic [NUM_TIMERS-1:0] next_prev;

	// first stage stands in for the half-cycle latch of a two-phase sampler
	always_comb begin
		next_stage1 = port.pin; // R6
		next_stage2 = stage1;
		next_prev   = stage2;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= '0;
			stage2 <= '0;
			prev   <= '0;
		end else if (port.ce) begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
			prev   <= next_prev;
		end
	end

	assign port.rise = stage2 & ~prev; // R6
	assign port.fall = ~stage2 & prev;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_chk
		rise_lag_a: assert property ( // R8
			(port.rise[i] && $past(port.ce, 1) && $past(port.ce, 2) && $past(port.ce, 3)
				&& $past(aresetn, 3))
			|-> ($past(port.pin[i], 2) && !$past(port.pin[i], 3)))
			else $error("rising edge pulse not three cycles after pin rise");
		fall_lag_a: assert property ( // R8
			(port.fall[i] && $past(port.ce, 1) && $past(port.ce, 2) && $past(port.ce, 3)
				&& $past(aresetn, 3))
			|-> (!$past(port.pin[i], 2) && $past(port.pin[i], 3)))
			else $error("falling edge pulse not three cycles after pin fall");
	end
endmodule : ext_pin_sync

// [rtl/tick_select_top.sv]
// Purpose: shared prescaler and tick source select for three timers
// Assumes: AXI4-Lite master; ce low only while the bus is idle
// Notes:   counters are minimal so the ticks can be seen and loaded
// Operation
// [R1] select 1 ticks every system clock
// [R2] taps divide by 8, 64, 256, 1024
// [R3] one free-running prescaler shared by all timers
// [R4] first prescaled tick within 1 to N+1
// [R5] prescaler reset restarts all timers' division
// [R6] pin sampled by synchroniser then edge detector
// [R7] select 7 rising edges, 6 falling edges
// [R8] counter updates about three cycles after edge
// [R9] software toggles external input only when stable
// [R10] external clock below half system clock
// [R11] external edges bypass the prescaler
// [R12] hold bit keeps prescaler resets asserted
// [R13] clearing hold bit clears both reset bits
// [R14] shared reset bit self-clears unless hold set
// [R15] no source selected gives no ticks
// [R16] select 0 stops; counter stays accessible
// [R17] codes 2..5 pick taps ascending
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module tick_select_top (
	// clock, reset, freeze
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic                          ce,
	// axi4-lite write address and data
	input  wire logic [tick_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic [2:0]                    awprot,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	// axi4-lite write response
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	// axi4-lite read
	input  wire logic [tick_pkg::ADDR_W-1:0]   araddr,
	input  wire logic [2:0]                    arprot,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	// count pins and tick outputs
	input  wire logic [tick_pkg::NUM_TIMERS-1:0] ext_count_pin,
	output logic [tick_pkg::NUM_TIMERS-1:0]    timer_tick,
	output logic                               other_prescaler_reset
);
	import tick_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	ext_pin_if pins ();
	assign pins.pin = ext_count_pin;
	assign pins.ce  = ce;

	ext_pin_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.port    (pins.sync)
	);

	logic [7:0]            ctrl;
	logic [7:0]            next_ctrl;
	logic [11:0]           sel_reg;
	logic [11:0]           next_sel;
	logic [31:0]           sel_word;
	logic [PRESC_W-1:0]    presc;
	logic [PRESC_W-1:0]    next_presc;
	logic [CNT_W-1:0]      cnt [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] tick_c;
	logic [NUM_TIMERS-1:0] wr_cnt;
	logic                  wr_fire;
	logic                  wr_ctrl;
	logic                  wr_sel;
	logic                  wr_hit;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic                  ar_fire;
	logic                  next_rvalid;
	logic [31:0]           next_rdata;
	logic [1:0]            next_rresp;
	logic [31:0]           rd_word;
	logic                  rd_hit;
	logic                  shared_psr;
	logic                  tap8;
	logic                  tap64;
	logic                  tap256;
	logic                  tap1024;

	// both write channels taken together, one write in flight
	assign awready = ce && !bvalid && awvalid && wvalid;
	assign wready  = awready;
	assign wr_fire = awready;
	assign wr_ctrl = wr_fire && awaddr == CTRL_OFF && wstrb[0];
	assign wr_sel  = wr_fire && awaddr == SEL_OFF;

	always_comb begin
		wr_hit = awaddr == CTRL_OFF || awaddr == SEL_OFF || awaddr == PRESC_OFF;
		for (int i = 0; i < NUM_TIMERS; i++) begin
			wr_cnt[i] = wr_fire && awaddr == CNT_OFF + 8'(i * 4);
			if (awaddr == CNT_OFF + 8'(i * 4)) begin
				wr_hit = 1'b1;
			end
		end
		next_bvalid = wr_fire || (bvalid && !bready);
		next_bresp  = bresp;
		if (wr_fire) begin
			next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (ce) begin
			bvalid <= next_bvalid;
			bresp  <= next_bresp;
		end
	end

	// control: reset bits drop back unless the hold bit keeps them
	always_comb begin
		next_ctrl = ctrl;
		if (!ctrl[HOLD_BIT]) begin
			next_ctrl[SHARED_PSR_BIT] = 1'b0; // R13 R14
			next_ctrl[OTHER_PSR_BIT]  = 1'b0; // R13
		end
		if (wr_ctrl) begin
			next_ctrl = wdata[7:0] & CTRL_MASK; // R12
		end
		// a function result cannot be part-selected, so merge into a word first
		sel_word = merge({20'h00000, sel_reg}, wdata, wstrb);
		next_sel = sel_reg;
		if (wr_sel) begin
			next_sel = sel_word[11:0] & SEL_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl    <= CTRL_RESET;
			sel_reg <= SEL_RESET;
		end else if (ce) begin
			ctrl    <= next_ctrl;
			sel_reg <= next_sel;
		end
	end

	assign shared_psr            = ctrl[SHARED_PSR_BIT];
	assign other_prescaler_reset = ctrl[OTHER_PSR_BIT];

	// one counter serves every timer, so a reset shifts all their phases
	always_comb begin
		next_presc = shared_psr ? '0 : presc + 1'b1; // R3 R5
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc <= '0;
		end else if (ce) begin
			presc <= next_presc;
		end
	end

	// taps fire on the last count of each period; held reset halts them
	assign tap8    = !shared_psr && &presc[DIV8_LOG2-1:0]; // R2 R4
	assign tap64   = !shared_psr && &presc[DIV64_LOG2-1:0];
	assign tap256  = !shared_psr && &presc[DIV256_LOG2-1:0];
	assign tap1024 = !shared_psr && &presc[DIV1024_LOG2-1:0];

	for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tim
		tick_src_t      src;
		logic [CNT_W-1:0] next_cnt;
		logic [31:0]      merged;
		logic             tick_one;

		assign src = tick_src_t'(sel_reg[i*SEL_STRIDE +: SEL_W]);

		// one local per timer keeps each tick bit with a single driver
		always_comb begin
			case (src)
				SEL_STOP:     tick_one = 1'b0; // R15 R16
				SEL_DIRECT:   tick_one = 1'b1; // R1
				SEL_DIV8:     tick_one = tap8; // R17
				SEL_DIV64:    tick_one = tap64;
				SEL_DIV256:   tick_one = tap256;
				SEL_DIV1024:  tick_one = tap1024;
				SEL_EXT_FALL: tick_one = pins.fall[i]; // R7 R11
				SEL_EXT_RISE: tick_one = pins.rise[i]; // R7 R11
				default:      tick_one = 1'b0;
			endcase
		end

		assign tick_c[i] = tick_one;

		// a bus write beats a tick in the same cycle
		always_comb begin
			merged   = merge({16'h0000, cnt[i]}, wdata, wstrb);
			next_cnt = cnt[i];
			if (wr_cnt[i]) begin
				next_cnt = merged[CNT_W-1:0]; // R16
			end else if (tick_c[i]) begin
				next_cnt = cnt[i] + 1'b1; // R8
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cnt[i] <= CNT_RESET;
			end else if (ce) begin
				cnt[i] <= next_cnt;
			end
		end

		direct_count_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
			(src == SEL_DIRECT && ce && !wr_cnt[i]) |=> cnt[i] == $past(cnt[i]) + 16'h1)
			else $error("direct select did not count every cycle");
		tap64_phase_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
			(src == SEL_DIV64 && tick_c[i]) |-> (presc[5:0] == 6'h3f && !shared_psr))
			else $error("divide-by-64 tick off its prescaler phase");
		stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R15
			(src == SEL_STOP && ce && !wr_cnt[i]) |=> cnt[i] == $past(cnt[i]))
			else $error("stopped timer changed its count");
		ext_pass_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
			(aresetn && src == SEL_EXT_RISE && pins.rise[i] && ce && !wr_cnt[i])
			|=> cnt[i] == $past(cnt[i]) + 16'h1)
			else $error("external tick not passed straight through");
		cpu_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
			(wr_cnt[i] && wstrb == 4'hf && ce) |=> cnt[i] == $past(wdata[15:0]))
			else $error("counter write lost against a tick");
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_tick <= '0;
		end else if (ce) begin
			timer_tick <= tick_c;
		end
	end

	// read channel
	assign arready = ce && !rvalid;
	assign ar_fire = arvalid && arready;

	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		case (araddr)
			CTRL_OFF:  rd_word = {24'h000000, ctrl};
			SEL_OFF:   rd_word = {20'h00000, sel_reg};
			PRESC_OFF: rd_word = {22'h0, presc};
			default:   rd_hit  = 1'b0;
		endcase
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (araddr == CNT_OFF + 8'(i * 4)) begin
				rd_word = {16'h0000, cnt[i]};
				rd_hit  = 1'b1;
			end
		end
		next_rvalid = ar_fire || (rvalid && !rready);
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (ar_fire) begin
			next_rdata = rd_word;
			next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= RESP_OKAY;
		end else if (ce) begin
			rvalid <= next_rvalid;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	psr_pulse_a: assert property ( // R14
		(shared_psr && !ctrl[HOLD_BIT] && !wr_ctrl && ce) |=> !shared_psr)
		else $error("shared prescaler reset did not self-clear");
	hold_keep_a: assert property ( // R12
		(ctrl[HOLD_BIT] && shared_psr && !wr_ctrl && ce) |=> shared_psr)
		else $error("hold bit failed to keep prescaler reset");
	release_a: assert property ( // R13
		(wr_ctrl && !wdata[HOLD_BIT] && ce) ##1 (ce && !wr_ctrl)
		|=> (!shared_psr && !other_prescaler_reset))
		else $error("reset bits not cleared after hold release");
	presc_reset_a: assert property ( // R5
		(shared_psr && ce) |=> presc == 10'h000)
		else $error("prescaler not restarted by reset bit");
	free_run_a: assert property ( // R3
		(aresetn && !shared_psr && ce) |=> presc == $past(presc) + 10'h001)
		else $error("prescaler did not run freely");
endmodule : tick_select_top

// [sim/ext_clock_src.sv]
// Purpose: external clock source on the three count pins
// Assumes: pins start low; run held for whole periods ends them low
// Notes:   all pins toggle together so rising and falling selects see one stream
`timescale 1ns/1ns
module ext_clock_src (
	// clock
	input  wire logic       aclk,
	// control
	input  wire logic       run,
	input  wire logic [3:0] half,
	// count pins
	output logic      [2:0] pin
);
	logic [3:0] cnt = 4'h0;
	initial pin = 3'h0;
	// half period of two or more cycles keeps below aclk/2.5
	always @(posedge aclk) begin
		if (!run) begin
			cnt <= 4'h0;
		end else if (cnt == half - 4'h1) begin
			cnt <= 4'h0;
			pin <= ~pin;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : ext_clock_src

// [sim/test_tick_select_top.sv]
// Purpose: self-checking bench for the shared prescaler and tick select
// Assumes: ticks counted at the falling edge, bus driven after rising edges
// Notes:   tick counts are taken over whole tap periods so phase drops out
`timescale 1ns/1ns
module test_tick_select_top;
	import tick_pkg::*;
	logic        aclk = 0, aresetn = 0, ce = 1, run = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0]  wstrb = 0, half = 4'h2;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, other_rst;
	logic [1:0]  bresp, rresp, rs;
	logic [2:0]  pin, tick;
	int          bad_count = 0, total_checks = 0, n;
	int          tick_cnt[3] = '{0, 0, 0}, t0[3];

	tick_select_top i_tick_select_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_count_pin(pin),
		.timer_tick(tick), .other_prescaler_reset(other_rst));
	ext_clock_src i_ext_clock_src (.aclk(aclk), .run(run), .half(half), .pin(pin));

	always #2 aclk = ~aclk;
	// falling edge keeps the monitor clear of the bench's own edge
	always @(negedge aclk) for (int i = 0; i < 3; i++) tick_cnt[i] += int'(tick[i]);

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a; wdata <= d; wstrb <= 4'hf;
		awvalid <= 1; wvalid <= 1; bready <= 1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 0; wvalid <= 0;
		while (!bvalid) @(posedge aclk);
		r = bresp;
		bready <= 0;
	endtask : wr
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		while (!rvalid) @(posedge aclk);
		d = rdata; r = rresp;
		rready <= 0;
	endtask : rdr
	task automatic window(input int cyc);
		t0 = tick_cnt;
		repeat (cyc) @(posedge aclk);
		for (int i = 0; i < 3; i++) t0[i] = tick_cnt[i] - t0[i];
	endtask : window

	task automatic t_reset;
		rdr(CTRL_OFF, rd, rs); check("ctrl", rd, 32'(CTRL_RESET));
		rdr(SEL_OFF, rd, rs); check("sel", rd, 32'(SEL_RESET));
		rdr(CNT_OFF, rd, rs); check("cnt0", rd, 32'(CNT_RESET));
		rdr(8'h40, rd, rs); check("unmapped rresp", 32'(rs), 32'(RESP_SLVERR));
		check("unmapped rdata", rd, 32'h0);
		wr(8'h40, 32'h1, rs); check("unmapped bresp", 32'(rs), 32'(RESP_SLVERR));
	endtask : t_reset
	task automatic t_taps;
		wr(SEL_OFF, 32'h432, rs);
		window(1024);
		check("div8", 32'(t0[0]), 32'd128);
		check("div64", 32'(t0[1]), 32'd16);
		check("div256", 32'(t0[2]), 32'd4);
		wr(SEL_OFF, 32'h015, rs);
		window(2048);
		check("div1024", 32'(t0[0]), 32'd2);
		check("direct", 32'(t0[1]), 32'd2048);
		check("stopped", 32'(t0[2]), 32'd0);
	endtask : t_taps
	task automatic t_sync;
		wr(SEL_OFF, 32'h122, rs);
		wr(CTRL_OFF, 32'h81, rs);
		rdr(CTRL_OFF, rd, rs); check("held ctrl", rd, 32'h81);
		rdr(PRESC_OFF, rd, rs); check("held presc", rd, 32'h0);
		window(64);
		check("held t0", 32'(t0[0]), 32'd0);
		check("held t1", 32'(t0[1]), 32'd0);
		wr(CTRL_OFF, 32'h00, rs);
		n = 0;
		do begin @(posedge aclk); n++; end while (!tick[0] && n < 20);
		check("first tick bound", 32'(n <= 9), 32'h1);
		rdr(CTRL_OFF, rd, rs); check("released ctrl", rd, 32'h0);
		n = 0;
		repeat (64) begin @(posedge aclk); n += int'(tick[0] !== tick[1]); end
		check("aligned ticks", 32'(n), 32'd0);
		wr(CTRL_OFF, 32'h01, rs);
		rdr(CTRL_OFF, rd, rs); check("self clear", rd, 32'h0);
		wr(CTRL_OFF, 32'h82, rs);
		check("other reset on", 32'(other_rst), 32'h1);
		// hold dropped with both reset bits still written: hardware must clear them
		wr(CTRL_OFF, 32'h03, rs);
		repeat (2) @(posedge aclk);
		check("other reset off", 32'(other_rst), 32'h0);
		rdr(CTRL_OFF, rd, rs); check("bits cleared", rd, 32'h0);
	endtask : t_sync
	task automatic t_stop;
		wr(SEL_OFF, 32'h000, rs);
		wr(CNT_OFF, 32'h1234, rs);
		repeat (50) @(posedge aclk);
		rdr(CNT_OFF, rd, rs); check("stopped cnt", rd, 32'h1234);
	endtask : t_stop
	task automatic t_freeze;
		logic [31:0] seen[2];
		// same sequence twice, 20 cycles with ce low first, then with ce high
		wr(SEL_OFF, 32'h010, rs);
		for (int k = 0; k < 2; k++) begin
			wr(CNT_OFF + CNT_STRIDE, 32'h0, rs);
			ce <= 1'(k);
			repeat (20) @(posedge aclk);
			ce <= 1'b1;
			rdr(CNT_OFF + CNT_STRIDE, seen[k], rs);
		end
		check("freeze gap", seen[1] - seen[0], 32'd20);
	endtask : t_freeze
	task automatic t_ext;
		// pin sits low and stable while the select changes
		wr(SEL_OFF, 32'h067, rs);
		t0 = tick_cnt;
		@(posedge aclk); run <= 1;
		repeat (40) @(posedge aclk);
		run <= 0;
		repeat (8) @(posedge aclk);
		for (int i = 0; i < 3; i++) t0[i] = tick_cnt[i] - t0[i];
		check("rise ticks", 32'(t0[0]), 32'd10);
		check("fall ticks", 32'(t0[1]), 32'd10);
		check("pin stop", 32'(t0[2]), 32'd0);
		run <= 1;
		do @(posedge aclk); while (!pin[0]);
		n = 0;
		do begin @(posedge aclk); n++; end while (!tick[0] && n < 10);
		check("edge lag", 32'(n), 32'd3);
		run <= 0;
	endtask : t_ext

	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		t_reset();
		t_taps();
		t_sync();
		t_stop();
		t_freeze();
		t_ext();
		stop_test();
	end
endmodule : test_tick_select_top
